// *** rtl/frp_reset_power.sv ***
// Purpose: Reset qualification, recovery lockout, power-on defaults, table tail
// Assumes: Reset and select pins are asynchronous to CLOCK
// Notes: Program and erase engines live outside; this block aborts them
`timescale 1ns/1ps

// Overview of operation
// - Reset pin low for at least 10 us resets the device.
// - After a reset cycle the device sits in standby awaiting commands.
// - Reset returns latch, busy flag and volatile lock bits to defaults.
// - Reset during program or erase aborts it; data may be corrupted.
// - Data output stays high impedance throughout the reset cycle.
// - Recovery is 40 us after decode, 35 us after read.
// - Recovery after an interrupted page program is 310 us.
// - Erase recovery: 12 ms sector, 25 ms block, 100 ms chip.
// - Recovery after an interrupted status write is 40 ms.
// - Power-up leaves standby, not deep power-down, with latch cleared.
// - Below write-inhibit threshold logic is held in reset, commands ignored.
// - Table reports wrap read supported, opcode C0h, lengths code 64h.
// - Table lock word reads CFFEh.
// - Table reports OTP support, no read lock, no permanent lock.
// - Unused table bytes read FFh.
// - Table read accepted only in single, dual-all and quad-all modes.
// - Read inserts dummy cycles after address or mode bits.
// - Software reset needs 66h immediately before 99h.
module frp_reset_power #(
  parameter int RESET_LOW_CYCLES = frp_pkg::RESET_LOW_CYC,
  parameter int DECODE_CYCLES = frp_pkg::DECODE_CYC,
  parameter int READ_CYCLES = frp_pkg::READ_CYC,
  parameter int PROGRAM_CYCLES = frp_pkg::PROGRAM_CYC,
  parameter int SECTOR_CYCLES = frp_pkg::SECTOR_CYC,
  parameter int BLOCK_CYCLES = frp_pkg::BLOCK_CYC,
  parameter int CHIP_CYCLES = frp_pkg::CHIP_CYC,
  parameter int STATUS_CYCLES = frp_pkg::STATUS_CYC,
  parameter int SUPPLY_CYCLES = frp_pkg::SUPPLY_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Pins from the host
  input wire logic RESET_PIN_N,
  input wire logic SELECT_N,
  // Power-on detector, high while supply is below write-inhibit threshold
  input wire logic BELOW_WRITE_INHIBIT,
  // Command decoder
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic [2:0] OP_KIND,
  input wire logic WEL_SET,
  input wire logic WEL_CLEAR,
  input wire logic WIP_SET,
  input wire logic WIP_CLEAR,
  input wire logic LOCK_WRITE,
  input wire logic [7:0] LOCK_IN,
  // Table read request
  input wire logic TBL_REQ,
  input wire logic [1:0] TBL_IO_MODE,
  input wire logic [7:0] TBL_ADDR,
  input wire logic [3:0] TBL_WAIT_STATES,
  // Status and control out
  output logic STANDBY,
  output logic DEEP_POWER_DOWN,
  output logic CMD_ACCEPT,
  output logic OP_ABORT,
  output logic WRITE_ENABLE_LATCH,
  output logic WRITE_IN_PROGRESS,
  output logic [7:0] LOCK_BITS,
  output logic DATA_OUT_OE,
  output logic TBL_REFUSED,
  output logic TBL_VALID,
  output logic [7:0] TBL_DATA
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic rst_meta_q, rst_sync_q, sel_meta_q, sel_sync_q, inh_meta_q, inh_sync_q;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
      inh_meta_q <= 1'b1;
      inh_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= RESET_PIN_N;
      rst_sync_q <= rst_meta_q;
      sel_meta_q <= SELECT_N;
      sel_sync_q <= sel_meta_q;
      inh_meta_q <= BELOW_WRITE_INHIBIT;
      inh_sync_q <= inh_meta_q;
    end
  end

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  typedef enum logic [2:0] {ST_POWER, ST_SETTLE, ST_STANDBY, ST_PULSE, ST_RECOVER} frp_state_e;
  frp_state_e state_q, state_d;
  logic [frp_pkg::CNT_W-1:0] cnt_q, cnt_d, rec_len_q, rec_len_d;
  logic arm_q, arm_d, abort_q, abort_d;
  logic sw_reset;
  logic por_hold;

  assign por_hold = inh_sync_q;

  // Recovery picked from the operation in flight when the pulse began
  function automatic logic [frp_pkg::CNT_W-1:0] rec_for(input logic [2:0] k);
    unique case (k)
      frp_pkg::OP_DECODE: rec_for = frp_pkg::CNT_W'(DECODE_CYCLES);
      frp_pkg::OP_READ: rec_for = frp_pkg::CNT_W'(READ_CYCLES);
      frp_pkg::OP_PROGRAM: rec_for = frp_pkg::CNT_W'(PROGRAM_CYCLES);
      frp_pkg::OP_SECTOR: rec_for = frp_pkg::CNT_W'(SECTOR_CYCLES);
      frp_pkg::OP_BLOCK: rec_for = frp_pkg::CNT_W'(BLOCK_CYCLES);
      frp_pkg::OP_CHIP: rec_for = frp_pkg::CNT_W'(CHIP_CYCLES);
      frp_pkg::OP_STATUS: rec_for = frp_pkg::CNT_W'(STATUS_CYCLES);
      default: rec_for = frp_pkg::CNT_W'(READ_CYCLES);
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rec_len_d = rec_len_q;
    arm_d = arm_q;
    abort_d = 1'b0;
    // Software reset: enable must be the command immediately before
    if (CMD_VALID && CMD_ACCEPT) begin
      arm_d = (CMD_CODE == frp_pkg::CMD_RESET_ENABLE);
    end
    if (por_hold) begin
      state_d = ST_POWER;
      cnt_d = '0;
      arm_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_POWER: begin
          state_d = ST_SETTLE;
          cnt_d = '0;
        end
        ST_SETTLE: begin
          // Commands waited out until supply settled
          cnt_d = cnt_q + 1'b1;
          if (cnt_q >= frp_pkg::CNT_W'(SUPPLY_CYCLES - 1)) state_d = ST_STANDBY;
        end
        ST_STANDBY: begin
          if (!rst_sync_q) begin
            state_d = ST_PULSE;
            cnt_d = '0;
            rec_len_d = rec_for(OP_KIND);
            abort_d = (OP_KIND >= frp_pkg::OP_PROGRAM);
          end else if (sw_reset) begin
            state_d = ST_RECOVER;
            cnt_d = '0;
            rec_len_d = rec_for(OP_KIND);
            abort_d = (OP_KIND >= frp_pkg::OP_PROGRAM);
          end
        end
        ST_PULSE: begin
          // Short glitches return to standby without recovery; full pulse then recovery
          if (cnt_q < frp_pkg::CNT_W'(RESET_LOW_CYCLES)) cnt_d = cnt_q + 1'b1;
          if (rst_sync_q) begin
            state_d = (cnt_q >= frp_pkg::CNT_W'(RESET_LOW_CYCLES)) ? ST_RECOVER
                                                                   : ST_STANDBY;
            cnt_d = '0;
          end
        end
        ST_RECOVER: begin
          cnt_d = cnt_q + 1'b1;
          if (!rst_sync_q) begin
            state_d = ST_PULSE;
            cnt_d = '0;
          end else if (cnt_q >= rec_len_q - 1'b1) begin
            state_d = ST_STANDBY;
          end
        end
        default: state_d = ST_POWER;
      endcase
    end
  end

  assign sw_reset = CMD_VALID && CMD_ACCEPT && arm_q && (CMD_CODE == frp_pkg::CMD_RESET);

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_POWER;
      cnt_q <= '0;
      rec_len_q <= '0;
      arm_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rec_len_q <= rec_len_d;
      arm_q <= arm_d;
      abort_q <= abort_d;
    end
  end

  logic in_reset;
  assign in_reset = (state_q == ST_PULSE) || (state_q == ST_RECOVER) || !rst_sync_q;
  // Commands gated during power hold, settling and recovery
  assign CMD_ACCEPT = (state_q == ST_STANDBY) && rst_sync_q && !por_hold
                      && !sel_sync_q;
  assign STANDBY = (state_q == ST_STANDBY);
  assign DEEP_POWER_DOWN = 1'b0;
  assign OP_ABORT = abort_q;

  // ****************************************************************
  // Volatile bits
  // ****************************************************************
  logic wel_q, wel_d, wip_q, wip_d;
  logic [7:0] lock_q, lock_d;
  logic clear_vol;
  assign clear_vol = in_reset || por_hold || (state_q == ST_POWER);

  always_comb begin
    wel_d = wel_q;
    wip_d = wip_q;
    lock_d = lock_q;
    if (clear_vol) begin
      wel_d = 1'b0;
      wip_d = 1'b0;
      lock_d = '0; // Default unprotected
    end else begin
      if (WEL_CLEAR) wel_d = 1'b0;
      if (WEL_SET) wel_d = 1'b1;
      if (WIP_CLEAR) wip_d = 1'b0;
      if (WIP_SET) wip_d = 1'b1;
      if (LOCK_WRITE) lock_d = LOCK_IN;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      lock_q <= '0;
    end else begin
      wel_q <= wel_d;
      wip_q <= wip_d;
      lock_q <= lock_d;
    end
  end
  assign WRITE_ENABLE_LATCH = wel_q;
  assign WRITE_IN_PROGRESS = wip_q;
  assign LOCK_BITS = lock_q;

  // ****************************************************************
  // Parameter table tail
  // ****************************************************************
  logic [7:0] byte_sel;
  logic mode_ok;
  logic [3:0] wait_q, wait_d;
  logic pend_q, pend_d, tv_q, tv_d, ref_q, ref_d;
  logic [7:0] tdata_q, tdata_d, addr_q, addr_d;

  assign mode_ok = (TBL_IO_MODE == frp_pkg::IO_SINGLE) || (TBL_IO_MODE == frp_pkg::IO_DUAL)
                   || (TBL_IO_MODE == frp_pkg::IO_QUAD);

  always_comb begin
    unique case (addr_q)
      8'h64: byte_sel = frp_pkg::MISC_WORD[7:0];
      8'h65: byte_sel = frp_pkg::MISC_WORD[15:8]; // Wrap read supported, bit 15
      8'h66: byte_sel = frp_pkg::WRAP_OPCODE;
      8'h67: byte_sel = frp_pkg::WRAP_LENGTHS;
      8'h68: byte_sel = frp_pkg::LOCK_WORD[7:0];
      8'h69: byte_sel = frp_pkg::LOCK_WORD[15:8]; // OTP yes, no read/permanent lock
      default: byte_sel = frp_pkg::BLANK_BYTE;
    endcase
  end

  always_comb begin
    pend_d = pend_q;
    wait_d = wait_q;
    addr_d = addr_q;
    tv_d = 1'b0;
    ref_d = 1'b0;
    tdata_d = tdata_q;
    if (TBL_REQ && !pend_q) begin
      if (mode_ok && CMD_ACCEPT) begin
        pend_d = 1'b1;
        wait_d = TBL_WAIT_STATES;
        addr_d = TBL_ADDR;
      end else begin
        ref_d = 1'b1;
      end
    end else if (pend_q) begin
      // Dummy cycles after address or mode bits before data
      if (wait_q != 4'h0) begin
        wait_d = wait_q - 4'h1;
      end else begin
        pend_d = 1'b0;
        tv_d = 1'b1;
        tdata_d = byte_sel;
      end
    end
    if (in_reset || por_hold) pend_d = 1'b0;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      pend_q <= 1'b0;
      wait_q <= '0;
      addr_q <= '0;
      tv_q <= 1'b0;
      ref_q <= 1'b0;
      tdata_q <= '0;
    end else begin
      pend_q <= pend_d;
      wait_q <= wait_d;
      addr_q <= addr_d;
      tv_q <= tv_d;
      ref_q <= ref_d;
      tdata_q <= tdata_d;
    end
  end
  assign TBL_VALID = tv_q;
  assign TBL_DATA = tdata_q;
  assign DATA_OUT_OE = tv_q && STANDBY && rst_sync_q; // Byte drives only outside reset
  assign TBL_REFUSED = ref_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence pulse_then_release;
    (state_q == ST_PULSE) ##1 (state_q == ST_RECOVER);
  endsequence

  short_glitch_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (state_q == ST_PULSE && rst_sync_q && cnt_q < RESET_LOW_CYCLES && !por_hold)
    |=> state_q == ST_STANDBY) else $error("short reset pulse not rejected");
  pulse_recover_a: assert property (@(posedge CLOCK) disable iff (RESET)
    pulse_then_release |-> $past(cnt_q) >= RESET_LOW_CYCLES)
    else $error("recovery entered before full pulse");
  recover_standby_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (state_q == ST_RECOVER && rst_sync_q && !por_hold && cnt_q >= rec_len_q - 1)
    |=> STANDBY) else $error("recovery did not end in standby");
  vol_clear_a: assert property (@(posedge CLOCK) disable iff (RESET)
    $past(in_reset) |-> !WRITE_ENABLE_LATCH && !WRITE_IN_PROGRESS && LOCK_BITS == 8'h00)
    else $error("volatile bits survived reset");
  abort_pulse_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (STANDBY && !rst_sync_q && !por_hold && OP_KIND == frp_pkg::OP_CHIP) |=> OP_ABORT)
    else $error("erase not aborted");
  output_off_a: assert property (@(posedge CLOCK) disable iff (RESET)
    in_reset |-> !DATA_OUT_OE) else $error("data output driven in reset");
  rec_length_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (STANDBY && !rst_sync_q && !por_hold && OP_KIND == frp_pkg::OP_PROGRAM)
    |=> rec_len_q == PROGRAM_CYCLES) else $error("wrong program recovery");
  por_ignore_a: assert property (@(posedge CLOCK) disable iff (RESET)
    por_hold |-> !CMD_ACCEPT ##1 !STANDBY) else $error("command accepted below threshold");
  recov_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (state_q == ST_RECOVER) |-> !CMD_ACCEPT) else $error("command taken in recovery");
  table_blank_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (TBL_VALID && $past(addr_q) > 8'h69) |-> TBL_DATA == 8'hFF)
    else $error("unused byte not blank");
  bad_mode_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (TBL_REQ && !pend_q && TBL_IO_MODE == 2'h3) |=> TBL_REFUSED && !pend_q)
    else $error("table read taken in bad mode");

endmodule

// *** rtl/frp_pkg.sv ***
// Purpose: Shared constants for the flash reset and power-on state block
// Assumes: 40 MHz core clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package frp_pkg;
  localparam int CLK_MHZ = 40;
  // Least times in microseconds or milliseconds; each converts exactly to whole cycles
  localparam int RESET_LOW_PULSE_MIN_US = 10;
  localparam int RECOVER_DECODE_US = 40;
  localparam int RECOVER_READ_US = 35;
  localparam int RECOVER_PROGRAM_US = 310;
  localparam int RECOVER_SECTOR_MS = 12;
  localparam int RECOVER_BLOCK_MS = 25;
  localparam int RECOVER_CHIP_MS = 100;
  localparam int RECOVER_STATUS_MS = 40;
  localparam int SUPPLY_TO_SELECT_US = 10;
  localparam int RESET_LOW_CYC = RESET_LOW_PULSE_MIN_US * CLK_MHZ;
  localparam int DECODE_CYC = RECOVER_DECODE_US * CLK_MHZ;
  localparam int READ_CYC = RECOVER_READ_US * CLK_MHZ;
  localparam int PROGRAM_CYC = RECOVER_PROGRAM_US * CLK_MHZ;
  localparam int SECTOR_CYC = RECOVER_SECTOR_MS * 1000 * CLK_MHZ;
  localparam int BLOCK_CYC = RECOVER_BLOCK_MS * 1000 * CLK_MHZ;
  localparam int CHIP_CYC = RECOVER_CHIP_MS * 1000 * CLK_MHZ;
  localparam int STATUS_CYC = RECOVER_STATUS_MS * 1000 * CLK_MHZ;
  localparam int SUPPLY_CYC = SUPPLY_TO_SELECT_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // Operation codes on OP_KIND
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_DECODE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_PROGRAM = 3'h3;
  localparam logic [2:0] OP_SECTOR = 3'h4;
  localparam logic [2:0] OP_BLOCK = 3'h5;
  localparam logic [2:0] OP_CHIP = 3'h6;
  localparam logic [2:0] OP_STATUS = 3'h7;
  // Parameter table tail, bytes 64h..6Fh
  localparam logic [7:0] TBL_FIRST = 8'h64;
  localparam logic [7:0] TBL_LAST = 8'h6F;
  localparam logic [7:0] WRAP_OPCODE = 8'hC0;
  localparam logic [7:0] WRAP_LENGTHS = 8'h64;
  localparam logic [15:0] LOCK_WORD = 16'hCFFE;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [15:0] MISC_WORD = 16'hF99D;
  // Transfer widths of the table read
  localparam logic [1:0] IO_SINGLE = 2'h0;
  localparam logic [1:0] IO_DUAL = 2'h1;
  localparam logic [1:0] IO_QUAD = 2'h2;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;
endpackage

// *** tb/frp_host.sv ***
// Purpose: Host side model driving the reset pin and chip select
// Assumes: Driven from the falling edge of the core clock
// Notes: Gap before select is scaled down with the bench recovery counts
`timescale 1ns/1ps
module frp_host #(
  parameter int GAP_CYCLES = 8
) (
  // Clock
  input wire logic clock,
  // Pins toward the device
  output logic reset_pin_n,
  output logic select_n
);
  // ****************************************
  // Pin sequencing
  // ****************************************
  initial begin
    reset_pin_n = 1'b1;
    select_n = 1'b1;
  end
  // Select is dropped on the same edge as the reset pin so a reset never lands inside a transfer
  task automatic pulse_reset(input int cycles);
    @(negedge clock);
    select_n = 1'b1;
    reset_pin_n = 1'b0;
    repeat (cycles) @(negedge clock);
    reset_pin_n = 1'b1;
  endtask
  // Select only after the reset pin has stood high for the gap
  task automatic select_device();
    repeat (GAP_CYCLES) @(negedge clock);
    select_n = 1'b0;
  endtask
  task automatic deselect();
    @(negedge clock);
    select_n = 1'b1;
  endtask
endmodule

// *** tb/flash_reset_and_power_on_state_tb.sv ***
// Purpose: Self-checking bench for reset, recovery, power-on and table tail
// Assumes: Recovery counts scaled down through the design parameters
// Notes: Sync delays on the pins are absorbed by a small tolerance
`timescale 1ns/1ps
module flash_reset_and_power_on_state_tb;
  // ****************************************
  // Signals and model
  // ****************************************
  // Scaled recovery counts, one per operation kind
  localparam int LOW_CYC = 8;
  localparam int SUPPLY_CYC = 10;
  localparam int DEC_CYC = 24;
  localparam int RD_CYC = 20;
  localparam int PP_CYC = 30;
  localparam int SEC_CYC = 38;
  localparam int BLK_CYC = 46;
  localparam int CHP_CYC = 54;
  localparam int WRS_CYC = 62;
  int rec [8] = '{RD_CYC, DEC_CYC, RD_CYC, PP_CYC, SEC_CYC, BLK_CYC, CHP_CYC, WRS_CYC};
  int fails = 0;
  int comparisons = 0;
  int aborts = 0;
  int a0;
  int n;
  logic clock, reset, below, cmd_valid, wel_set, wip_set, lock_write, tbl_req;
  logic wel_clear, wip_clear;
  logic [7:0] cmd_code, lock_in, tbl_addr;
  logic [2:0] op_kind;
  logic [1:0] tbl_mode;
  logic [3:0] tbl_waits;
  logic standby, dpd, accept, abort, write_enable_latch, write_in_progress, oe, refused, valid, pin_n, sel_n;
  logic [7:0] lock_bits, tbl_data;

  frp_host i_frp_host (.clock(clock), .reset_pin_n(pin_n), .select_n(sel_n));
  frp_reset_power #(.RESET_LOW_CYCLES(LOW_CYC), .DECODE_CYCLES(DEC_CYC),
    .READ_CYCLES(RD_CYC), .PROGRAM_CYCLES(PP_CYC), .SECTOR_CYCLES(SEC_CYC),
    .BLOCK_CYCLES(BLK_CYC), .CHIP_CYCLES(CHP_CYC), .STATUS_CYCLES(WRS_CYC),
    .SUPPLY_CYCLES(SUPPLY_CYC)) i_frp_reset_power (
    .CLOCK(clock), .RESET(reset), .RESET_PIN_N(pin_n), .SELECT_N(sel_n),
    .BELOW_WRITE_INHIBIT(below), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .OP_KIND(op_kind), .WEL_SET(wel_set), .WEL_CLEAR(wel_clear), .WIP_SET(wip_set),
    .WIP_CLEAR(wip_clear), .LOCK_WRITE(lock_write), .LOCK_IN(lock_in), .TBL_REQ(tbl_req),
    .TBL_IO_MODE(tbl_mode), .TBL_ADDR(tbl_addr), .TBL_WAIT_STATES(tbl_waits),
    .STANDBY(standby), .DEEP_POWER_DOWN(dpd), .CMD_ACCEPT(accept), .OP_ABORT(abort),
    .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS(write_in_progress), .LOCK_BITS(lock_bits),
    .DATA_OUT_OE(oe), .TBL_REFUSED(refused), .TBL_VALID(valid), .TBL_DATA(tbl_data));

  function automatic logic [7:0] tbl_exp(input logic [7:0] a);
    case (a)
      8'h64: return 8'h9D;
      8'h65: return 8'hF9;
      8'h66: return 8'hC0;
      8'h67: return 8'h64;
      8'h68: return 8'hFE;
      8'h69: return 8'hCF;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Drivers
  // ****************************************
  task automatic wait_standby(input int limit, output int cnt);
    cnt = 0;
    while (standby !== 1'b1 && cnt < limit) begin
      @(negedge clock);
      cnt++;
    end
  endtask

  task automatic set_volatile();
    @(negedge clock);
    // Clear pulses land with the sets: set must win
    {wel_set, wip_set, lock_write} = 3'h7;
    {wel_clear, wip_clear} = 2'h3;
    lock_in = 8'($urandom_range(8'hFF, 8'h01));
    @(negedge clock);
    {wel_set, wip_set, lock_write} = 3'h0;
    {wel_clear, wip_clear} = 2'h0;
    @(negedge clock);
    check(write_enable_latch === 1'b1 && write_in_progress === 1'b1 && lock_bits === lock_in, "volatile set");
  endtask

  task automatic cmd(input logic [7:0] code);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask

  // Answer may land one cycle late because of the output register
  task automatic tbl_read(input logic [1:0] mode, input logic [7:0] addr);
    int k;
    @(negedge clock);
    {tbl_req, tbl_mode, tbl_addr} = {1'b1, mode, addr};
    tbl_waits = 4'($urandom_range(15)); // Mode bits sit inside the dummy count
    @(negedge clock);
    tbl_req = 1'b0;
    k = 1;
    while (valid !== 1'b1 && refused !== 1'b1 && k < 24) begin
      @(negedge clock);
      k++;
    end
    if (mode == 2'h3) begin
      check(refused === 1'b1 && valid !== 1'b1 && k <= 2, "illegal mode taken");
    end else begin
      check(valid === 1'b1 && tbl_data === tbl_exp(addr), "table byte");
      check(k == tbl_waits + 2 || k == tbl_waits + 3, "wait states");
    end
  endtask

  // ****************************************
  // Monitor, clock, watchdog
  // ****************************************
  always @(negedge clock) begin
    if (!reset) begin
      if (abort === 1'b1) aborts++;
      check(oe === (valid === 1'b1 && standby === 1'b1) && dpd === 1'b0,
            "output enable or power-down");
      if (standby !== 1'b1) check(accept === 1'b0, "command taken out of standby");
    end
  end

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {reset, below} = 2'h3;
    {cmd_valid, wel_set, wip_set, lock_write, tbl_req, cmd_code, lock_in} = '0;
    {tbl_addr, op_kind, tbl_mode, tbl_waits} = '0;
    {wel_clear, wip_clear} = 2'h0;
    void'($urandom(32'hB286F8A0));
    repeat (20) @(negedge clock);
    reset = 1'b0;
    repeat (6) @(negedge clock);
    check(standby === 1'b0 && accept === 1'b0, "active below threshold");
    below = 1'b0;
    wait_standby(60, n);
    check(n >= SUPPLY_CYC && standby === 1'b1, "power-up settle");
    check(write_enable_latch === 1'b0 && write_in_progress === 1'b0 && lock_bits === 8'h00, "power-on defaults");
    i_frp_host.select_device();
    // Every operation kind, each with its recovery span; idle shares the read span
    for (int k = 0; k < 8; k++) begin
      set_volatile();
      op_kind = 3'(k);
      a0 = aborts;
      i_frp_host.pulse_reset(10);
      check(standby === 1'b0, "no reset cycle");
      fork
        i_frp_host.select_device();
        wait_standby(200, n);
      join
      check(n >= rec[k] && n <= rec[k] + 6, "recovery length");
      check((aborts - a0) == (k >= 3 ? 1 : 0), "abort pulse");
      check(standby === 1'b1 && write_enable_latch === 1'b0 && write_in_progress === 1'b0, "state after reset");
      check(lock_bits === 8'h00, "lock bits after reset");
      op_kind = 3'h0;
    end
    for (int m = 0; m < 4; m++) begin
      for (int a = 8'h64; a <= 8'h70; a++) begin
        tbl_read(2'(m), 8'(a));
      end
    end
    // Glitch below the minimum width: no recovery, volatile bits still dropped
    set_volatile();
    i_frp_host.pulse_reset(LOW_CYC - 5);
    check(standby === 1'b0, "glitch not seen");
    wait_standby(40, n);
    check(n <= 6 && standby === 1'b1 && write_enable_latch === 1'b0, "short pulse handling");
    i_frp_host.select_device();
    // Software reset: lone 99h does nothing, 66h then 99h resets
    set_volatile();
    cmd(8'h99);
    repeat (6) @(negedge clock);
    check(standby === 1'b1 && write_enable_latch === 1'b1, "lone reset command acted");
    cmd(8'h66);
    cmd(8'h99);
    repeat (4) @(negedge clock);
    check(standby === 1'b0, "software reset ignored");
    wait_standby(200, n);
    check(standby === 1'b1 && write_enable_latch === 1'b0 && lock_bits === 8'h00, "soft reset state");
    // Supply dip: logic held in reset, then settles again
    set_volatile();
    i_frp_host.deselect();
    below = 1'b1;
    repeat (5) @(negedge clock);
    check(standby === 1'b0 && write_enable_latch === 1'b0 && write_in_progress === 1'b0, "dip not reset");
    below = 1'b0;
    wait_standby(60, n);
    check(n >= SUPPLY_CYC && standby === 1'b1, "settle after dip");
    // Plain clear pulses drop latch and busy flag, lock bits stay
    set_volatile();
    {wel_clear, wip_clear} = 2'h3;
    @(negedge clock);
    {wel_clear, wip_clear} = 2'h0;
    @(negedge clock);
    check(write_enable_latch === 1'b0 && write_in_progress === 1'b0 && lock_bits === lock_in, "clear pulses");
    print_verdict();
  end
endmodule
